// >>> bench/serial0_baud_clock_gen_tb.sv
`timescale 1ns/100ps
`include "serial0_baud_regs.svh"
module serial0_baud_clock_gen_tb;
  logic        clk, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        rxd, txd, oe, ext_trig, gate;
  logic [1:0]  bresp, rresp;
  int          n_mismatch = 0;
  int          num_checks = 0;

  serial0_baud_clock_gen uut (.i_clk(clk), .i_resetn(resetn),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready), .i_p3_0(rxd), .o_p3_0(),
    .o_p3_0_oe(oe), .o_p3_1(txd), .i_timer2_external_trigger(ext_trig),
    .i_external_interrupt1_gate(gate));
  serial_peer peer (.i_clk(clk), .i_line(txd), .o_line(rxd));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Every wait is bounded; running out ends the run as a mismatch
  task automatic tick(inout int n);
    n++;
    if (n > 20000) begin
      n_mismatch++;
      $display("timeout at %0t", $time);
      stop_test();
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic ta, tw, tb;
    logic [1:0] rs;
    n = 0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      rs = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      tick(n);
    end while (!tb);
    check(rs, 32'h0);
    bready <= 1'b0;
  endtask

  task automatic rdreg(input logic [7:0] a, output logic [31:0] d);
    int   n;
    logic ta, tr;
    logic [1:0] rs;
    n = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid;
      d  = rdata;
      rs = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      tick(n);
    end while (!tr);
    check(rs, 32'h0);
    rready <= 1'b0;
  endtask

  // Transmit on timer 2, slow then fast prescale, trigger pin toggled
  task automatic test_tx();
    int n, f0;
    for (int k = 0; k < 2; k++) begin
      n  = 0;
      f0 = peer.frames;
      ext_trig <= !k[0];
      wr(`ADDR_CLOCK_CTRL, k ? 32'h30 : 32'h10);
      wr(`ADDR_TIMER2_RELOAD, 32'hfffe);
      wr(`ADDR_TIMER2_COUNT, 32'hffff);
      wr(`ADDR_TIMER2_CTRL, 32'h14);
      wr(`ADDR_SERIAL0_CTRL, 32'h50);
      peer.armed = 1'b1;
      wr(`ADDR_TX_DATA, 32'ha5);
      while (peer.frames == f0) begin
        @(posedge clk);
        tick(n);
      end
      check(peer.got, 32'ha5);
      check(peer.stop_ok, 32'h1);
      check(peer.period, k ? 128 : 384);
      check(oe, 32'h0);
      repeat (peer.period) @(posedge clk);
      rdreg(`ADDR_SERIAL0_CTRL, rd);
      check(rd[1], 32'h1);
      rdreg(`ADDR_TIMER2_CTRL, rd);
      check(rd[7], 32'h0);
      check(rd[6], 32'h0);
      wr(`ADDR_SERIAL0_CTRL, 32'h50);
      rdreg(`ADDR_SERIAL0_CTRL, rd);
      check(rd[1:0], 32'h0);
    end
    $display("test tx finished");
  endtask

  // Receive on timer 1 mode 2, doubled then plain rate
  task automatic test_rx();
    wr(`ADDR_TIMER2_CTRL, 32'h04);
    wr(`ADDR_TIMER_MODE, 32'h20);
    wr(`ADDR_TIMER1_COUNT, 32'hfefe);
    wr(`ADDR_TIMER_CTRL, 32'h40);
    for (int k = 0; k < 2; k++) begin
      wr(`ADDR_POWER_CTRL, k ? 32'h00 : 32'h80);
      wr(`ADDR_SERIAL0_CTRL, 32'h50);
      peer.send(k ? 8'h3d : 8'h3c, k ? 256 : 128);
      repeat (k ? 128 : 64) @(posedge clk);
      rdreg(`ADDR_SERIAL0_CTRL, rd);
      check(rd[0], 32'h1);
      rdreg(`ADDR_RX_DATA, rd);
      check(rd[7:0], k ? 32'h3d : 32'h3c);
    end
    $display("test rx finished");
  endtask

  // Timer 2 with run bit clear must send nothing
  task automatic test_halt();
    int f0;
    f0 = peer.frames;
    wr(`ADDR_TIMER2_CTRL, 32'h10);
    wr(`ADDR_TX_DATA, 32'h81);
    repeat (1000) @(posedge clk);
    check(peer.frames, f0);
    $display("test halt finished");
  endtask

  // Gated timer 1: counts with run and gate, stalls otherwise
  task automatic test_gate();
    wr(`ADDR_TIMER_MODE, 32'ha0);
    wr(`ADDR_POWER_CTRL, 32'h80);
    for (int k = 0; k < 3; k++) begin
      gate <= (k != 1);
      wr(`ADDR_TIMER_CTRL, (k != 2) ? 32'h40 : 32'h00);
      wr(`ADDR_SERIAL0_CTRL, 32'h50);
      peer.send(8'h99, 128);
      repeat (64) @(posedge clk);
      rdreg(`ADDR_SERIAL0_CTRL, rd);
      check(rd[0], (k == 0) ? 32'h1 : 32'h0);
    end
    $display("test gate finished");
  endtask

  initial begin
    resetn   = 1'b0;
    awaddr   = 8'h00;
    araddr   = 8'h00;
    wdata    = 32'h0;
    wstrb    = 4'hf;
    awvalid  = 1'b0;
    wvalid   = 1'b0;
    bready   = 1'b0;
    arvalid  = 1'b0;
    rready   = 1'b0;
    ext_trig = 1'b0;
    gate     = 1'b1;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rdreg(`ADDR_TIMER2_RELOAD, rd);
    check(rd[15:0], `RST_TIMER2_RELOAD);
    rdreg(8'h3c, rd);
    check(rd, 32'h0);
    test_tx();
    test_rx();
    test_halt();
    test_gate();
    stop_test();
  end
endmodule

// >>> bench/serial_peer.sv
`timescale 1ns/100ps
// Remote 8N1 partner: sends frames and catches what the block sends
module serial_peer (
  input  wire logic i_clk,
  input  wire logic i_line,
  output logic      o_line
);
  logic       armed   = 1'b0;
  logic [7:0] got;
  logic       stop_ok;
  int         period;
  int         frames  = 0;

  // Marking level while idle, so a stray low is never read as a start
  initial o_line = 1'b1;

  // frame build
  // Start, eight bits LSB first, stop; bit time in clocks
  task automatic send(input logic [7:0] b, input int p);
    @(posedge i_clk);
    o_line <= 1'b0;
    repeat (p) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      o_line <= b[i];
      repeat (p) @(posedge i_clk);
    end
    o_line <= 1'b1;
    repeat (p) @(posedge i_clk);
  endtask

  // frame catch
  // Start bit length gives the bit time; callers keep data bit 0 high
  initial begin
    forever begin
      @(posedge i_clk);
      if (armed && i_line === 1'b0) begin
        period = 0;
        while (i_line === 1'b0) begin
          @(posedge i_clk);
          period++;
        end
        repeat (period / 2) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
          got[i] = i_line;
          repeat (period) @(posedge i_clk);
        end
        stop_ok = i_line;
        frames++;
      end
    end
  end
endmodule

// >>> hw/serial0_baud_clock_gen.sv
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "serial0_baud_regs.svh"
// Function
// - Mode 1 uses port3 bit0 as receive, bit1 as transmit; modes 2-3 start no frames.
// - Mode 0 makes port3 bit1 shift clock; bit0 is driven only while a frame begun in mode 1 is still sending.
// - Timer 2 overflow pulse divided by 16 forms bit clock.
// - Timer 2 rollover reloads the count pair from the reload pair.
// - Baud-generating timer 2 overflows raise no overflow flag.
// - Per-direction select bit picks timer 2 or timer 1 overflow.
// - Timer 2 counts only while its run bit is set.
// - Timer 2 may ignore its external trigger pin entirely.
// - Mode 1 frame is start, eight data, stop: ten bits.
// - Control write with data bits 1:0 zero clears both flags, unless a done sets one in that cycle.
// - Doubling bit doubles the timer 1 derived rate.
// - Timer 2 rate is osc/(192*(65536-reload)), divide-by-4 triples it.
// - Timer 1 mode 2 is 8-bit, reloading from high byte.
// - Timer 1 rate scales with doubling, prescale and 256-reload.
// - Cleared timer 1 run bit stops timer 1 baud clocks.
// - Clock select bit picks divide-by-4 or divide-by-12 timer 2.
// - Gated timer 1 counts only with run bit and gate input.
// - Timer 2 preset all ones overflows on the next timer clock.
module serial0_baud_clock_gen
  import serial0_baud_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire logic        i_p3_0,
  output logic             o_p3_0,
  output logic             o_p3_0_oe,
  output logic             o_p3_1,
  input  wire logic        i_timer2_external_trigger,
  input  wire logic        i_external_interrupt1_gate
);
  logic [7:0]  serial0_control_reg, timer2_control_reg, clock_control_reg;
  logic [7:0]  power_control_reg, timer_mode_reg, timer_control_reg;
  logic [15:0] timer2_reload_pair, timer2_count_pair;
  logic [7:0]  timer1_count_reg, timer1_reload_byte, rx_data_reg;
  logic [7:0]  tx_data_reg;
  logic        tx_start_reg;
  logic [1:0]  rx_sync_reg, timer2_external_trigger_sync_reg, gate_sync_reg;
  logic        timer2_external_trigger_prev_reg;
  logic [3:0]  t1_pre_reg, t2_pre_reg;
  logic        t1_half_reg;
  logic [3:0]  tx_div_reg, rx_div_reg;
  logic        aw_got_reg, w_got_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  line_state_t tx_state_reg, rx_state_reg;
  shift_t      tx_sh_reg, rx_sh_reg;
  logic        tx_line_reg, rx_prev_reg;
  logic [3:0]  rx_phase_reg;
  logic        tx_done_set, rx_done_set;

  // One clock and one reset for every assertion below
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  // Byte-lane merge for an 8-bit register in lane 0
  function automatic logic [7:0] merge8(input logic [7:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    merge8 = s[0] ? d[7:0] : old;
  endfunction

  // Write channel capture, address and data in either order
  wire wr_fire = aw_got_reg && w_got_reg && !o_bvalid;
  assign o_awready = !aw_got_reg;
  assign o_wready  = !w_got_reg;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      o_bvalid    <= 1'b0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_got_reg  <= 1'b1;
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end
      if (wr_fire) begin
        o_bvalid   <= 1'b1;
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end
  assign o_bresp = 2'b00;
  wire [7:0] waddr = aw_addr_reg;

  // Read channel, unmapped addresses read zero with OKAY
  assign o_arready = !o_rvalid;
  assign o_rresp   = 2'b00;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      case (i_araddr)
        `ADDR_SERIAL0_CTRL:  o_rdata <= {24'h0, serial0_control_reg};
        `ADDR_TIMER2_CTRL:   o_rdata <= {24'h0, timer2_control_reg};
        `ADDR_CLOCK_CTRL:    o_rdata <= {24'h0, clock_control_reg};
        `ADDR_POWER_CTRL:    o_rdata <= {24'h0, power_control_reg};
        `ADDR_TIMER_MODE:    o_rdata <= {24'h0, timer_mode_reg};
        `ADDR_TIMER_CTRL:    o_rdata <= {24'h0, timer_control_reg};
        `ADDR_TIMER2_RELOAD: o_rdata <= {16'h0, timer2_reload_pair};
        `ADDR_TIMER2_COUNT:  o_rdata <= {16'h0, timer2_count_pair};
        `ADDR_TIMER1_COUNT:
          o_rdata <= {16'h0, timer1_reload_byte, timer1_count_reg};
        `ADDR_RX_DATA:       o_rdata <= {24'h0, rx_data_reg};
        default:             o_rdata <= 32'h0000_0000;
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_sync_reg   <= 2'b11;
      timer2_external_trigger_sync_reg <= 2'b00;
      gate_sync_reg <= 2'b00;
    end else begin
      rx_sync_reg   <= {rx_sync_reg[0], i_p3_0};
      timer2_external_trigger_sync_reg <= {timer2_external_trigger_sync_reg[0], i_timer2_external_trigger};
      gate_sync_reg <= {gate_sync_reg[0], i_external_interrupt1_gate};
    end
  end
  wire rx_pin = rx_sync_reg[1];

  // Prescalers: divide-by-12 or divide-by-4 timer ticks
  // prescale select
  wire t2_fast = clock_control_reg[`CK_T2_FAST];
  wire t1_fast = clock_control_reg[`CK_T1_FAST];
  wire t2_tick = (t2_pre_reg == (t2_fast ? `PRESCALE_FAST : `PRESCALE_SLOW));
  wire t1_tick = (t1_pre_reg == (t1_fast ? `PRESCALE_FAST : `PRESCALE_SLOW));
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      t2_pre_reg <= 4'h0;
      t1_pre_reg <= 4'h0;
    end else begin
      t2_pre_reg <= t2_tick ? 4'h0 : t2_pre_reg + 4'h1;
      t1_pre_reg <= t1_tick ? 4'h0 : t1_pre_reg + 4'h1;
    end
  end

  // Timer 2 baud mode when either direction selects it
  wire t2_baud = timer2_control_reg[`T2_RX_SRC] |
                 timer2_control_reg[`T2_TX_SRC];
  wire t2_count = timer2_control_reg[`T2_RUN] && t2_tick;
  wire t2_ovf = t2_count && (timer2_count_pair == 16'hffff);
  wire timer2_external_trigger_fall = timer2_control_reg[`T2_EXT_EN] &&
                   timer2_external_trigger_prev_reg && !timer2_external_trigger_sync_reg[1];

  // divide chain 32 (16 with doubling) * prescale * (256 - reload)
  wire t1_gate_ok = !timer_mode_reg[`TM_T1_GATE] || gate_sync_reg[1];
  wire t1_count = timer_control_reg[`TC_T1_RUN] && t1_gate_ok && t1_tick;
  wire t1_mode2 = timer_mode_reg[`TM_T1_MODE_HI:`TM_T1_MODE_LO] == 2'b10;
  wire t1_ovf_raw = t1_count && t1_mode2 && (timer1_count_reg == 8'hff);
  wire t1_ovf = t1_ovf_raw && (power_control_reg[`PC_DOUBLE] || t1_half_reg);

  // Register writes and timers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      serial0_control_reg <= 8'h00;
      timer2_control_reg  <= 8'h00;
      clock_control_reg   <= 8'h00;
      power_control_reg   <= 8'h00;
      timer_mode_reg      <= 8'h00;
      timer_control_reg   <= 8'h00;
      timer2_reload_pair  <= `RST_TIMER2_RELOAD;
      timer2_count_pair   <= `RST_TIMER2_COUNT;
      timer1_count_reg    <= 8'h00;
      timer1_reload_byte  <= 8'h00;
      t1_half_reg         <= 1'b0;
      timer2_external_trigger_prev_reg       <= 1'b0;
      tx_data_reg         <= 8'h00;
      tx_start_reg        <= 1'b0;
    end else begin
      timer2_external_trigger_prev_reg <= timer2_external_trigger_sync_reg[1];
      tx_start_reg  <= 1'b0;
      if (t2_ovf) begin
        timer2_count_pair <= timer2_reload_pair;
      end else if (t2_count) begin
        timer2_count_pair <= timer2_count_pair + 16'h0001;
      end
      if (t1_ovf_raw) begin
        timer1_count_reg <= timer1_reload_byte;
        t1_half_reg      <= !t1_half_reg;
      end else if (t1_count) begin
        timer1_count_reg <= timer1_count_reg + 8'h01;
      end
      // no overflow flag in baud mode
      if (t2_ovf && !t2_baud) begin
        timer2_control_reg[`T2_OVF_FLAG] <= 1'b1;
      end
      if (timer2_external_trigger_fall && !t2_baud) begin
        timer2_control_reg[6] <= 1'b1;
      end
      if (tx_done_set) begin
        serial0_control_reg[`SC_TX_DONE] <= 1'b1;
      end
      if (rx_done_set) begin
        serial0_control_reg[`SC_RX_DONE] <= 1'b1;
      end
      if (wr_fire) begin
        case (waddr)
          `ADDR_SERIAL0_CTRL: begin
            serial0_control_reg <= {merge8(serial0_control_reg, w_data_reg,
                w_strb_reg)} | {6'h00, tx_done_set, rx_done_set};
          end
          `ADDR_TIMER2_CTRL: begin
            timer2_control_reg <= merge8(timer2_control_reg, w_data_reg,
                w_strb_reg) | {t2_ovf && !t2_baud, timer2_external_trigger_fall && !t2_baud,
                6'h00};
          end
          `ADDR_CLOCK_CTRL:
            clock_control_reg <= merge8(clock_control_reg, w_data_reg,
                w_strb_reg);
          `ADDR_POWER_CTRL:
            power_control_reg <= merge8(power_control_reg, w_data_reg,
                w_strb_reg);
          `ADDR_TIMER_MODE:
            timer_mode_reg <= merge8(timer_mode_reg, w_data_reg,
                w_strb_reg);
          `ADDR_TIMER_CTRL:
            timer_control_reg <= merge8(timer_control_reg, w_data_reg,
                w_strb_reg);
          `ADDR_TIMER2_RELOAD: begin
            if (w_strb_reg[0]) timer2_reload_pair[7:0] <= w_data_reg[7:0];
            if (w_strb_reg[1]) timer2_reload_pair[15:8] <= w_data_reg[15:8];
          end
          `ADDR_TIMER2_COUNT: begin
            if (w_strb_reg[0]) timer2_count_pair[7:0] <= w_data_reg[7:0];
            if (w_strb_reg[1]) timer2_count_pair[15:8] <= w_data_reg[15:8];
          end
          `ADDR_TIMER1_COUNT: begin
            if (w_strb_reg[0]) timer1_count_reg <= w_data_reg[7:0];
            if (w_strb_reg[1]) timer1_reload_byte <= w_data_reg[15:8];
          end
          `ADDR_TX_DATA: begin
            tx_data_reg  <= w_data_reg[7:0];
            tx_start_reg <= w_strb_reg[0];
          end
          default: ;
        endcase
      end
    end
  end

  wire tx_src = timer2_control_reg[`T2_TX_SRC] ? t2_ovf : t1_ovf;
  wire rx_src = timer2_control_reg[`T2_RX_SRC] ? t2_ovf : t1_ovf;
  wire tx_bit = tx_src && (tx_div_reg == `BIT_DIV);
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_div_reg <= 4'h0;
      rx_div_reg <= 4'h0;
    end else begin
      if (tx_src) tx_div_reg <= tx_div_reg + 4'h1;
      if (rx_src) rx_div_reg <= rx_div_reg + 4'h1;
    end
  end

  // tick ratio gives the timer 2 rate
  // Transmitter; a byte written mid-frame is dropped
  wire mode1 = serial0_control_reg[`SC_MODE_HI:`SC_MODE_LO] == 2'b01;
  assign tx_done_set = tx_bit && (tx_state_reg == LINE_STOP);
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_state_reg <= LINE_IDLE;
      tx_sh_reg    <= '0;
      tx_line_reg  <= 1'b1;
    end else begin
      case (tx_state_reg)
        LINE_IDLE: if (tx_start_reg && mode1) begin
          tx_sh_reg    <= '{data: tx_data_reg, count: 4'h0};
          tx_state_reg <= LINE_START;
        end
        LINE_START: if (tx_bit) begin
          tx_line_reg  <= 1'b0;
          tx_state_reg <= LINE_DATA;
        end
        LINE_DATA: if (tx_bit) begin
          tx_line_reg     <= tx_sh_reg.data[0];
          tx_sh_reg.data  <= {1'b0, tx_sh_reg.data[7:1]};
          tx_sh_reg.count <= tx_sh_reg.count + 4'h1;
          if (tx_sh_reg.count == 4'h7) tx_state_reg <= LINE_STOP;
        end
        LINE_STOP: if (tx_bit) begin
          tx_line_reg  <= 1'b1;
          tx_state_reg <= LINE_IDLE;
        end
        default: tx_state_reg <= LINE_IDLE;
      endcase
    end
  end

  // Receiver samples mid-bit, 16 overflow ticks per bit
  wire rx_en = serial0_control_reg[`SC_RX_EN] && mode1;
  wire rx_mid = rx_src && (rx_phase_reg == 4'h7);
  assign rx_done_set = rx_mid && (rx_state_reg == LINE_STOP) && rx_pin;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_state_reg <= LINE_IDLE;
      rx_sh_reg    <= '0;
      rx_phase_reg <= 4'h0;
      rx_prev_reg  <= 1'b1;
      rx_data_reg  <= 8'h00;
    end else begin
      rx_prev_reg <= rx_pin;
      if (rx_src) rx_phase_reg <= rx_phase_reg + 4'h1;
      case (rx_state_reg)
        LINE_IDLE: if (rx_en && rx_prev_reg && !rx_pin) begin
          rx_phase_reg <= 4'h0;
          rx_state_reg <= LINE_START;
        end
        LINE_START: if (rx_mid) begin
          rx_sh_reg    <= '0;
          rx_state_reg <= rx_pin ? LINE_IDLE : LINE_DATA;
        end
        LINE_DATA: if (rx_mid) begin
          rx_sh_reg.data  <= {rx_pin, rx_sh_reg.data[7:1]};
          rx_sh_reg.count <= rx_sh_reg.count + 4'h1;
          if (rx_sh_reg.count == 4'h7) rx_state_reg <= LINE_STOP;
        end
        LINE_STOP: if (rx_mid) begin
          if (rx_pin) rx_data_reg <= rx_sh_reg.data;
          rx_state_reg <= LINE_IDLE;
        end
        default: rx_state_reg <= LINE_IDLE;
      endcase
    end
  end

  // port 3 pins in modes 1-3
  // mode 0 shift clock and data
  wire mode0 = serial0_control_reg[`SC_MODE_HI:`SC_MODE_LO] == 2'b00;
  assign o_p3_1    = mode0 ? rx_div_reg[3] : tx_line_reg;
  assign o_p3_0    = tx_line_reg;
  assign o_p3_0_oe = mode0 && (tx_state_reg != LINE_IDLE);

  // reload after rollover; a count write wins
  a_t2_reload_next: assert property (
    t2_ovf && !wr_fire |=> timer2_count_pair == $past(timer2_reload_pair))
    else $error("timer 2 did not reload");
  a_t2_no_flag: assert property (
    t2_ovf && t2_baud && !wr_fire |=>
      !$rose(timer2_control_reg[`T2_OVF_FLAG]))
    else $error("baud overflow set flag");
  a_t2_run_hold: assert property (
    !timer2_control_reg[`T2_RUN] && !wr_fire |=> $stable(timer2_count_pair))
    else $error("timer 2 moved while stopped");
  a_t1_stop_quiet: assert property (
    !timer_control_reg[`TC_T1_RUN] && !wr_fire |=>
      $stable(timer1_count_reg))
    else $error("timer 1 counted while stopped");
  a_t1_gate_hold: assert property (
    timer_mode_reg[`TM_T1_GATE] && !gate_sync_reg[1] && !wr_fire |=>
      $stable(timer1_count_reg))
    else $error("gated timer 1 counted");
  a_tx_src_pick: assert property (
    timer2_control_reg[`T2_TX_SRC] && !t2_ovf |=> $stable(tx_div_reg))
    else $error("wrong transmit source");
  a_tx_done_stop: assert property (
    tx_done_set |=> o_p3_1 || mode0)
    else $error("done without stop bit");
  a_t2_ffff_ovf: assert property (
    t2_count && timer2_count_pair == 16'hffff |-> t2_ovf)
    else $error("all ones did not overflow");
  c_tx_frame: cover property (@(posedge i_clk) disable iff (!i_resetn)
    tx_done_set);
  c_rx_frame: cover property (@(posedge i_clk) disable iff (!i_resetn)
    rx_done_set);
  c_t1_ovf: cover property (@(posedge i_clk) disable iff (!i_resetn)
    t1_ovf);
endmodule

// >>> hw/serial0_baud_pkg.sv
package serial0_baud_pkg;
  typedef enum logic [1:0] {
    LINE_IDLE  = 2'b00,
    LINE_START = 2'b01,
    LINE_DATA  = 2'b10,
    LINE_STOP  = 2'b11
  } line_state_t;
  typedef struct packed {
    logic [7:0] data;
    logic [3:0] count;
  } shift_t;
endpackage

// >>> hw/serial0_baud_regs.svh
`ifndef SERIAL0_BAUD_REGS_SVH
`define SERIAL0_BAUD_REGS_SVH
// Register byte addresses
`define ADDR_SERIAL0_CTRL    8'h00
`define ADDR_TIMER2_CTRL     8'h04
`define ADDR_CLOCK_CTRL      8'h08
`define ADDR_POWER_CTRL      8'h0c
`define ADDR_TIMER_MODE      8'h10
`define ADDR_TIMER_CTRL      8'h14
`define ADDR_TIMER2_RELOAD   8'h18
`define ADDR_TIMER2_COUNT    8'h1c
`define ADDR_TIMER1_COUNT    8'h20
`define ADDR_TX_DATA         8'h24
`define ADDR_RX_DATA         8'h28
// Serial control fields
`define SC_MODE_HI           7
`define SC_MODE_LO           6
`define SC_RX_EN             4
`define SC_TX_DONE           1
`define SC_RX_DONE           0
// Timer 2 control fields
`define T2_OVF_FLAG          7
`define T2_RX_SRC            5
`define T2_TX_SRC            4
`define T2_EXT_EN            3
`define T2_RUN               2
// Other fields
`define CK_T1_FAST           4
`define CK_T2_FAST           5
`define PC_DOUBLE            7
`define TM_T1_GATE           7
`define TM_T1_MODE_HI        5
`define TM_T1_MODE_LO        4
`define TC_T1_RUN            6
// Reset values and counts
`define RST_TIMER2_RELOAD    16'h0000
`define RST_TIMER2_COUNT     16'h0000
`define PRESCALE_SLOW        4'd11
`define PRESCALE_FAST        4'd3
`define BIT_DIV              4'd15
`define FRAME_BITS           4'd10
`endif
